/* dshp_port.sv */
// Function
// - strap low four-wire, high three-wire nine-bit
// - lowest data pin clock, next data
// - four-wire: command low, data high, rising
// - capture only on rising serial clock
// - four-wire bytes shifted msb first
// - completed byte routed to ram or command
// - write only, no read-back
// - three-wire word: flag then bits seven-zero
// - flag one ram, flag zero command
// - three-wire ignores data/command pin
`timescale 1ns/1ps
`include "dshp_consts.svh"
module dshp_port
   import dshp_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       bus_mode_strap,
   input  wire logic       cs_n_pin,
   input  wire logic       dc_pin,
   input  wire logic       clock_pin,
   input  wire logic       data_pin,
   output logic            ram_wr_r,
   output logic            cmd_wr_r,
   output logic [7:0]      wr_byte_r,
   output logic            three_wire_r,
   output logic            data_pin_o_r,
   output logic            data_pin_oe_r,
   output logic            clock_pin_o_r,
   output logic            clock_pin_oe_r
);
   logic                   cs_n_s;
   logic                   dc_s;
   logic                   sck_rise;
   logic                   sdi_s;
   logic                   strap_s;
   logic [`DSHP_CNT_W-1:0] cnt_r;
   logic [`DSHP_CNT_W-1:0] cnt_nxt;
   logic [8:0]             shreg_r;
   logic [8:0]             shreg_nxt;
   logic                   last_bit;
   logic                   word_done;
   dshp_mode_e             mode_r;
   dshp_byte_s             done_byte;

   // index of the bit that closes a unit; three-wire adds the flag
   function automatic logic [`DSHP_CNT_W-1:0] last_index(
      input dshp_mode_e mode
   );
      int bits;
      bits = (mode == DSHP_THREE_WIRE) ? `DSHP_WORD3_BITS :
         `DSHP_BYTE_BITS;
      bits = bits - 1;
      return bits[`DSHP_CNT_W-1:0];
   endfunction

   // dc pin and leading flag share one encoding
   function automatic logic flag_is_data(
      input logic flag
   );
      return flag == `DSHP_FLAG_DATA;
   endfunction

   dshp_sync3 #(.RST_VAL(`DSHP_SYNC_RST_CS)) u_cs (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .async_in (cs_n_pin),
      .level    (cs_n_s),
      .rise     ()
   );

   dshp_sync3 #(.RST_VAL(`DSHP_SYNC_RST)) u_dc (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .async_in (dc_pin),
      .level    (dc_s),
      .rise     ()
   );

   // idle serial clock is low, so reset low gives no false edge
   dshp_sync3 #(.RST_VAL(`DSHP_SYNC_RST)) u_sck (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .async_in (clock_pin),
      .level    (),
      .rise     (sck_rise)
   );

   // data level lags the clock edge by one clock; host setup time covers it
   dshp_sync3 #(.RST_VAL(`DSHP_SYNC_RST)) u_sdi (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .async_in (data_pin),
      .level    (sdi_s),
      .rise     ()
   );

   dshp_sync3 #(.RST_VAL(`DSHP_SYNC_RST)) u_bs (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .async_in (bus_mode_strap),
      .level    (strap_s),
      .rise     ()
   );

   // mode follows the strap only between transfers, so a glitch
   // on the strap never splits a word
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mode_r <= DSHP_FOUR_WIRE;
      end else if (cs_n_s) begin
         mode_r <= strap_s ? DSHP_THREE_WIRE : DSHP_FOUR_WIRE;
      end
   end

   assign last_bit  = (cnt_r == last_index(mode_r));
   assign word_done = !cs_n_s && sck_rise && last_bit;

   always_comb begin
      cnt_nxt = cnt_r;
      if (cs_n_s) begin
         cnt_nxt = '0;
      end else if (sck_rise) begin
         cnt_nxt = last_bit ? '0 : cnt_r + 1'h1;
      end
   end

   // stale bits stay behind; the counter alone frames a unit
   always_comb begin
      shreg_nxt = shreg_r;
      if (!cs_n_s && sck_rise) begin
         shreg_nxt = {shreg_r[7:0], sdi_s};
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         shreg_r <= '0;
      end else begin
         shreg_r <= shreg_nxt;
      end
   end

   // three-wire: bit 8 of shreg is the leading flag; dc pin unused
   always_comb begin
      done_byte.value = shreg_nxt[7:0];
      if (mode_r == DSHP_THREE_WIRE) begin
         done_byte.is_data = flag_is_data(shreg_nxt[8]);
      end else begin
         done_byte.is_data = flag_is_data(dc_s);
      end
   end

   // strobes rise on the same edge the last bit lands in shreg
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ram_wr_r <= 1'h0;
      end else begin
         ram_wr_r <= word_done && done_byte.is_data;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cmd_wr_r <= 1'h0;
      end else begin
         cmd_wr_r <= word_done && !done_byte.is_data;
      end
   end

   // byte holds until the next unit, so slow sinks can lag
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wr_byte_r <= 8'h00;
      end else if (word_done) begin
         wr_byte_r <= done_byte.value;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         three_wire_r <= 1'h0;
      end else begin
         three_wire_r <= (mode_r == DSHP_THREE_WIRE);
      end
   end

   // pins are receive only; the host never gets a read-back
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         data_pin_o_r <= 1'h0;
      end else begin
         data_pin_o_r <= 1'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         data_pin_oe_r <= 1'h0;
      end else begin
         data_pin_oe_r <= 1'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         clock_pin_o_r <= 1'h0;
      end else begin
         clock_pin_o_r <= 1'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         clock_pin_oe_r <= 1'h0;
      end else begin
         clock_pin_oe_r <= 1'h0;
      end
   end
endmodule

/* dshp_consts.svh */
`ifndef DSHP_CONSTS_SVH
`define DSHP_CONSTS_SVH
`define DSHP_BYTE_BITS      8
`define DSHP_WORD3_BITS     9
`define DSHP_CNT_W          4
`define DSHP_FLAG_DATA      1'h1
`define DSHP_FLAG_CMD       1'h0
`define DSHP_SYNC_RST       3'h0
`define DSHP_SYNC_RST_CS    3'h7
`endif

/* dshp_pkg.sv */
package dshp_pkg;
   typedef enum logic {
      DSHP_FOUR_WIRE,
      DSHP_THREE_WIRE
   } dshp_mode_e;
   typedef struct packed {
      logic       is_data;
      logic [7:0] value;
   } dshp_byte_s;
endpackage

/* dshp_sync3.sv */
`timescale 1ns/1ps
`include "dshp_consts.svh"
module dshp_sync3 #(
   parameter logic [2:0] RST_VAL = 3'h0
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic async_in,
   output logic      level,
   output logic      rise
);
   logic [2:0] sh_r;
   logic       level_r;
   // stage 0 feeds only stage 1
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sh_r <= RST_VAL;
      end else begin
         sh_r <= {sh_r[1:0], async_in};
      end
   end
   // a change counts once stages 1 and 2 agree
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         level_r <= RST_VAL[2];
      end else if (sh_r[1] == sh_r[2]) begin
         level_r <= sh_r[2];
      end
   end
   assign rise  = (sh_r[1] == sh_r[2]) && sh_r[2] && !level_r;
   assign level = level_r;
endmodule

/* dshp_port_properties.sv */
`timescale 1ns/1ps
module dshp_port_checker (
   input wire logic       clock,
   input wire logic       sys_rst,
   input wire logic       bus_mode_strap,
   input wire logic       cs_n_pin,
   input wire logic       ram_wr_r,
   input wire logic       cmd_wr_r,
   input wire logic [7:0] wr_byte_r,
   input wire logic       three_wire_r,
   input wire logic       data_pin_o_r,
   input wire logic       data_pin_oe_r,
   input wire logic       clock_pin_o_r,
   input wire logic       clock_pin_oe_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_excl; !(ram_wr_r && cmd_wr_r); endproperty
   a_excl: assert property (p_excl) else $error("two strobes");
   property p_gap; ram_wr_r || cmd_wr_r |=> !(ram_wr_r || cmd_wr_r) [*8];
   endproperty
   a_gap: assert property (p_gap) else $error("strobe too long");
   property p_hold; !$stable(wr_byte_r) |-> ram_wr_r || cmd_wr_r; endproperty
   a_hold: assert property (p_hold) else $error("byte moved");
   property p_cs; cs_n_pin [*8] |-> !(ram_wr_r || cmd_wr_r); endproperty
   a_cs: assert property (p_cs) else $error("strobe while idle");
   property p_mode; (cs_n_pin && $stable(bus_mode_strap)) [*6]
      |=> three_wire_r == $past(bus_mode_strap); endproperty
   a_mode: assert property (p_mode) else $error("mode wrong");
   property p_oe; !data_pin_oe_r; endproperty
   a_oe: assert property (p_oe) else $error("data driven");
   property p_coe; !clock_pin_oe_r; endproperty
   a_coe: assert property (p_coe) else $error("clock driven");
   property p_out; !(data_pin_o_r || clock_pin_o_r); endproperty
   a_out: assert property (p_out) else $error("output set");
endmodule
bind dshp_port dshp_port_checker dshp_port_checker_inst (.clock, .sys_rst,
   .bus_mode_strap, .cs_n_pin, .ram_wr_r, .cmd_wr_r, .wr_byte_r,
   .three_wire_r, .data_pin_o_r, .data_pin_oe_r, .clock_pin_o_r,
   .clock_pin_oe_r);

/* dshp_host.sv */
`timescale 1ns/1ps
module dshp_host (
   input  wire logic clock,
   output logic      cs_n,
   output logic      dc,
   output logic      sck,
   output logic      sdo
);
   initial {cs_n, dc, sck, sdo} = 4'h8;
   // four clocks a level, beyond the three-flop sync
   task automatic shift(input logic d, input logic [8:0] w, input int n);
      dc <= d;
      for (int i = n - 1; i >= 0; i--) begin
         cs_n <= 1'b0;
         sdo <= w[i];
         repeat (4) @(posedge clock);
         sck <= 1'b1;
         repeat (4) @(posedge clock);
         sck <= 1'b0;
      end
   endtask
   task automatic idle();
      repeat (4) @(posedge clock);
      cs_n <= 1'b1;
      sdo <= ~sdo; // idle line driven to the inverse of its last bit, not released
      repeat (8) @(posedge clock);
   endtask
endmodule

/* dshp_port_bench.sv */
`timescale 1ns/1ps
module dshp_port_bench;
   import dshp_pkg::*;
   logic       clock = 1'b0;
   logic       sys_rst = 1'b1;
   logic       strap = 1'b0;
   logic       cs_n, dc, sck, sdo, ram, cmd, tw;
   logic [7:0] byt;
   dshp_byte_s got[$];
   int         err_total = 0;
   int         samples_checked = 0;
   always #12.5 clock = ~clock;
   dshp_host dshp_host_inst (.clock, .cs_n, .dc, .sck, .sdo);
   dshp_port dshp_port_inst (.clock, .sys_rst, .bus_mode_strap(strap),
      .cs_n_pin(cs_n), .dc_pin(dc), .clock_pin(sck), .data_pin(sdo),
      .ram_wr_r(ram), .cmd_wr_r(cmd), .wr_byte_r(byt), .three_wire_r(tw),
      .data_pin_o_r(), .data_pin_oe_r(), .clock_pin_o_r(),
      .clock_pin_oe_r());
   always @(posedge clock)
      if (ram === 1'b1 || cmd === 1'b1) got.push_back('{ram, byt});
   task automatic bad(input logic [8:0] g, input logic [8:0] e);
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
   endtask
   task automatic expect_word(input dshp_byte_s e);
      for (int n = 0; n < 40 && got.size() == 0; n++) @(posedge clock);
      samples_checked++;
      if (got.size() == 0) begin
         bad(9'h1FF, e);
         summarize();
      end
      if (got[0] !== e) bad(got[0], e);
      got.pop_front();
   endtask
   task automatic check_mode(input logic e);
      samples_checked++;
      if (tw !== e) bad({8'h00, tw}, {8'h00, e});
   endtask
   task automatic four_wire();
      dshp_host_inst.shift(1'b0, 9'h0A5, 8);
      dshp_host_inst.shift(1'b1, 9'h03C, 8);
      dshp_host_inst.idle();
      expect_word('{1'b0, 8'hA5});
      expect_word('{1'b1, 8'h3C});
      $display("four-wire done");
   endtask
   task automatic three_wire();
      strap <= 1'b1;
      repeat (8) @(posedge clock);
      check_mode(1'b1);
      dshp_host_inst.shift(1'h0, 9'h0C3, 9);
      dshp_host_inst.shift(1'h0, 9'h15A, 9);
      dshp_host_inst.idle();
      expect_word('{1'h0, 8'hC3});
      expect_word('{1'h1, 8'h5A});
      $display("three-wire done");
   endtask
   task automatic abort();
      strap <= 1'h0;
      repeat (8) @(posedge clock);
      check_mode(1'h0);
      dshp_host_inst.shift(1'b1, 9'h01F, 5);
      dshp_host_inst.idle();
      dshp_host_inst.shift(1'b1, 9'h081, 8);
      dshp_host_inst.idle();
      expect_word('{1'b1, 8'h81});
      $display("abort done");
   endtask
   task automatic summarize();
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      check_mode(1'b0);
      four_wire();
      three_wire();
      abort();
      summarize();
   end
endmodule
